// [serial_flash_command_front_end.sv]
// serial flash command front end with its read data fifo
`timescale 1ns/1ps
`include "flash_front_params.svh"

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_in, // system clock
  input wire logic nrst_in, // sync reset, active low
  input wire logic flush_in, // drop all entries
  input wire logic [WIDTH-1:0] in_data_in, // fill data
  input wire logic in_valid_in, // fill data valid
  output logic in_ready_out, // room for one more
  output logic [WIDTH-1:0] out_data_out, // head entry
  output logic out_valid_out, // head entry valid
  input wire logic out_ready_in // drain takes head
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic push;
  logic pop;

  assign push = in_valid_in & in_ready_out;
  assign pop = out_ready_in & out_valid_out;
  assign out_data_out = mem[rd_ptr_r];

  always_comb begin
    count_nxt = count_r;
    if (flush_in) begin
      count_nxt = '0;
    end else if (push && !pop) begin
      count_nxt = count_r + CW'(1);
    end else if (pop && !push) begin
      count_nxt = count_r - CW'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      in_ready_out <= 1'b0;
      out_valid_out <= 1'b0;
    end else begin
      count_r <= count_nxt;
      in_ready_out <= (count_nxt != CW'(DEPTH));
      out_valid_out <= (count_nxt != '0);
      if (flush_in) begin
        wr_ptr_r <= '0;
        rd_ptr_r <= '0;
      end else begin
        if (push) begin
          wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + PW'(1);
        end
        if (pop) begin
          rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + PW'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (push && !flush_in) begin
      mem[wr_ptr_r] <= in_data_in;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////

module serial_flash_command_front_end
  import flash_front_pkg::*;
(
  input wire logic clk_in, // 20 MHz system clock
  input wire logic nrst_in, // sync reset, active low
  input wire logic cs_n_in, // chip select pin, active low
  input wire logic sck_in, // serial clock pin
  input wire logic [3:0] io_in, // io3..io0 pin levels
  output logic [3:0] io_out, // io3..io0 drive values
  output logic [3:0] io_oe_n_out, // io3..io0 enables, low drives
  output logic cmd_valid_out, // header complete pulse
  output logic [7:0] cmd_opcode_out, // accepted opcode
  output logic [19:0] cmd_addr_out, // array address
  output logic cmd_end_out, // accepted command ended pulse
  output logic crm_exit_out, // leave continuous read pulse
  output logic wr_valid_out, // received data byte pulse
  output logic [7:0] wr_byte_out, // received data byte
  output logic rd_active_out, // data output phase level
  output logic rd_underrun_out, // fill byte sent pulse
  input wire logic [7:0] rd_data_in, // read data to send
  input wire logic rd_valid_in, // read data valid
  output logic rd_ready_out // read fifo has room
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and clock edge detection

  logic cs_q1_r, cs_s_r;
  logic sck_q1_r, sck_s_r, sck_d_r;
  logic [3:0] io_q1_r, io_s_r;
  logic sck_rise, sck_fall, cs_act;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cs_q1_r <= 1'b1;
      cs_s_r <= 1'b1;
      sck_q1_r <= 1'b0;
      sck_s_r <= 1'b0;
      sck_d_r <= 1'b0;
      io_q1_r <= 4'h0;
      io_s_r <= 4'h0;
    end else begin
      cs_q1_r <= cs_n_in;
      cs_s_r <= cs_q1_r;
      sck_q1_r <= sck_in;
      sck_s_r <= sck_q1_r;
      sck_d_r <= sck_s_r;
      io_q1_r <= io_in;
      io_s_r <= io_q1_r;
    end
  end

  // idle clock level is never looked at, so modes 0 and 3 act alike
  assign sck_rise = sck_s_r & ~sck_d_r;
  assign sck_fall = ~sck_s_r & sck_d_r;
  assign cs_act = ~cs_s_r;

  ////////////////////////////////////////////////////////////////////////
  // opcode table

  function automatic cmd_info_t decode(input logic [7:0] opc);
    cmd_info_t i;
    i.known = 1'b1;
    i.addr_bytes = `ADDR_BYTES;
    i.dummy = 1'b0;
    i.dir = DIR_NONE;
    i.addr_lanes = LANE_1;
    i.data_lanes = LANE_1;
    case (opc)
      `OPC_READ_FAST, `OPC_SEC_READ: begin
        i.dummy = 1'b1;
        i.dir = DIR_OUT;
      end
      `OPC_READ_SLOW, `OPC_READ_ID_ADDR: begin
        i.dir = DIR_OUT;
      end
      `OPC_READ_DUAL: begin
        i.dummy = 1'b1;
        i.dir = DIR_OUT;
        i.data_lanes = LANE_2;
      end
      `OPC_READ_DUAL_IO: begin
        i.dir = DIR_OUT;
        i.addr_lanes = LANE_2;
        i.data_lanes = LANE_2;
      end
      `OPC_READ_QUAD: begin
        i.dummy = 1'b1;
        i.dir = DIR_OUT;
        i.data_lanes = LANE_4;
      end
      `OPC_READ_QUAD_IO: begin
        i.dummy = 1'b1;
        i.dir = DIR_OUT;
        i.addr_lanes = LANE_4;
        i.data_lanes = LANE_4;
      end
      `OPC_ERASE_4K, `OPC_ERASE_32K, `OPC_ERASE_64K: begin
        i.dir = DIR_NONE;
      end
      `OPC_SEC_ERASE: begin
        i.dir = DIR_NONE;
      end
      `OPC_PROGRAM, `OPC_SEC_PROGRAM: begin
        i.dir = DIR_IN;
      end
      `OPC_READ_SR1, `OPC_READ_SR2, `OPC_READ_JEDEC_ID: begin
        i.addr_bytes = 2'h0;
        i.dir = DIR_OUT;
      end
      `OPC_WRITE_SR: begin
        i.addr_bytes = 2'h0;
        i.dir = DIR_IN;
      end
      `OPC_CHIP_ERASE_A, `OPC_CHIP_ERASE_B, `OPC_WRITE_ENABLE,
      `OPC_WRITE_DISABLE, `OPC_VSR_ENABLE, `OPC_CRM_RESET: begin
        i.addr_bytes = 2'h0;
      end
      default: begin
        i.known = 1'b0;
      end
    endcase
    return i;
  endfunction

  function automatic phase_t after_dummy(input cmd_info_t i);
    case (i.dir)
      DIR_IN: return ST_DIN;
      DIR_OUT: return ST_DOUT;
      default: return ST_DONE;
    endcase
  endfunction

  function automatic phase_t after_addr(input cmd_info_t i);
    return i.dummy ? ST_DUMMY : after_dummy(i);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // input shifting

  phase_t state_r;
  cmd_info_t info_r, cur_info;
  logic [7:0] sh_r, sh_nxt, opc_r;
  logic [3:0] bit_cnt_r, in_step;
  logic [1:0] abyte_cnt_r;
  logic [23:0] addr_r, addr_full;
  logic [8:0] din_cnt_r, din_limit;
  logic shifting, byte_done, addr_last, hdr_done;
  lanes_t in_lanes;

  always_comb begin
    in_lanes = (state_r == ST_ADDR || state_r == ST_DUMMY) ?
               info_r.addr_lanes : LANE_1;
    case (in_lanes)
      LANE_2: begin
        sh_nxt = {sh_r[5:0], io_s_r[1], io_s_r[0]};
        in_step = 4'h2;
      end
      LANE_4: begin
        sh_nxt = {sh_r[3:0], io_s_r[3:0]};
        in_step = 4'h4;
      end
      default: begin
        sh_nxt = {sh_r[6:0], io_s_r[0]};
        in_step = 4'h1;
      end
    endcase
    shifting = (state_r == ST_OPC) || (state_r == ST_ADDR) ||
               (state_r == ST_DUMMY) || (state_r == ST_DIN);
    byte_done = sck_rise && cs_act && shifting &&
                (bit_cnt_r + in_step == `BITS_PER_BYTE);
    cur_info = decode(sh_nxt);
    addr_last = (abyte_cnt_r + 2'h1 == info_r.addr_bytes);
    addr_full = {addr_r[15:0], sh_nxt};
    // a command counts only once opcode and full address are in
    hdr_done = byte_done && ((state_r == ST_OPC && cur_info.known &&
               cur_info.addr_bytes == 2'h0) ||
               (state_r == ST_ADDR && addr_last));
    din_limit = (opc_r == `OPC_WRITE_SR) ? `WRSR_MAX_BYTES :
                `PROG_MAX_BYTES;
  end

  ////////////////////////////////////////////////////////////////////////
  // phase sequencing

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_r <= ST_IDLE;
      info_r <= '0;
      opc_r <= 8'h00;
      sh_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      abyte_cnt_r <= 2'h0;
      addr_r <= 24'h000000;
      din_cnt_r <= 9'h000;
    end else if (!cs_act) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      sh_r <= 8'h00;
    end else if (state_r == ST_IDLE) begin
      state_r <= ST_OPC;
      bit_cnt_r <= 4'h0;
      abyte_cnt_r <= 2'h0;
      addr_r <= 24'h000000;
      din_cnt_r <= 9'h000;
    end else if (sck_rise && shifting) begin
      sh_r <= sh_nxt;
      bit_cnt_r <= byte_done ? 4'h0 : bit_cnt_r + in_step;
      if (byte_done) begin
        case (state_r)
          ST_OPC: begin
            info_r <= cur_info;
            opc_r <= sh_nxt;
            if (!cur_info.known) begin
              state_r <= ST_IGNORE;
            end else if (cur_info.addr_bytes != 2'h0) begin
              state_r <= ST_ADDR;
            end else begin
              state_r <= after_addr(cur_info);
            end
          end
          ST_ADDR: begin
            addr_r <= addr_full;
            abyte_cnt_r <= abyte_cnt_r + 2'h1;
            if (addr_last) begin
              state_r <= after_addr(info_r);
            end
          end
          ST_DUMMY: begin
            state_r <= after_dummy(info_r);
          end
          default: begin
            if (din_cnt_r != din_limit) begin
              din_cnt_r <= din_cnt_r + 9'h001;
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // user side events

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cmd_valid_out <= 1'b0;
      cmd_opcode_out <= 8'h00;
      cmd_addr_out <= 20'h00000;
      cmd_end_out <= 1'b0;
      crm_exit_out <= 1'b0;
      wr_valid_out <= 1'b0;
      wr_byte_out <= 8'h00;
      rd_active_out <= 1'b0;
    end else begin
      cmd_valid_out <= hdr_done;
      if (hdr_done) begin
        cmd_opcode_out <= (state_r == ST_OPC) ? sh_nxt : opc_r;
        cmd_addr_out <= (state_r == ST_OPC) ? 20'h00000 :
                        addr_full[19:0];
      end
      crm_exit_out <= hdr_done && state_r == ST_OPC &&
                      sh_nxt == `OPC_CRM_RESET;
      cmd_end_out <= !cs_act && (state_r == ST_DUMMY ||
                     state_r == ST_DIN || state_r == ST_DOUT ||
                     state_r == ST_DONE);
      wr_valid_out <= byte_done && state_r == ST_DIN &&
                      din_cnt_r != din_limit;
      if (byte_done && state_r == ST_DIN) begin
        wr_byte_out <= sh_nxt;
      end
      rd_active_out <= cs_act && state_r == ST_DOUT;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data fifo and output shifter

  logic [7:0] fifo_data;
  logic fifo_valid, fifo_pop, load_slot;
  logic [7:0] out_sh_r, out_byte;
  logic [3:0] out_cnt_r, out_step, lane_mask_n;

  byte_fifo #(
    .WIDTH(`RD_FIFO_WIDTH),
    .DEPTH(`RD_FIFO_DEPTH)
  ) u_rd_fifo (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .flush_in(hdr_done),
    .in_data_in(rd_data_in),
    .in_valid_in(rd_valid_in),
    .in_ready_out(rd_ready_out),
    .out_data_out(fifo_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop)
  );

  always_comb begin
    case (info_r.data_lanes)
      LANE_2: begin
        out_step = 4'h2;
        lane_mask_n = 4'hC;
      end
      LANE_4: begin
        out_step = 4'h4;
        lane_mask_n = 4'h0;
      end
      default: begin
        out_step = 4'h1;
        lane_mask_n = 4'hD;
      end
    endcase
    load_slot = sck_fall && cs_act && state_r == ST_DOUT &&
                out_cnt_r == 4'h0;
    fifo_pop = load_slot && fifo_valid;
    out_byte = load_slot ? (fifo_valid ? fifo_data : `IDLE_FILL_BYTE) :
               out_sh_r;
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      out_sh_r <= 8'h00;
      out_cnt_r <= 4'h0;
      io_out <= 4'h0;
      rd_underrun_out <= 1'b0;
    end else begin
      rd_underrun_out <= load_slot && !fifo_valid;
      if (hdr_done) begin
        out_cnt_r <= 4'h0;
      end else if (sck_fall && cs_act && state_r == ST_DOUT) begin
        out_sh_r <= out_byte << out_step;
        out_cnt_r <= (out_cnt_r == 4'h0) ? `BITS_PER_BYTE - out_step :
                     out_cnt_r - out_step;
        case (info_r.data_lanes)
          LANE_2: io_out <= {2'b00, out_byte[7], out_byte[6]};
          LANE_4: io_out <= out_byte[7:4];
          default: io_out <= {2'b00, out_byte[7], 1'b0};
        endcase
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      io_oe_n_out <= 4'hF;
    end else begin
      io_oe_n_out <= (cs_act && state_r == ST_DOUT) ?
                     lane_mask_n : 4'hF;
    end
  end
endmodule

// [flash_front_params.svh]
// constants for the serial flash command front end
`ifndef FLASH_FRONT_PARAMS_SVH
`define FLASH_FRONT_PARAMS_SVH

`define OPC_READ_SLOW 8'h03
`define OPC_READ_FAST 8'h0B
`define OPC_READ_DUAL 8'h3B
`define OPC_READ_DUAL_IO 8'hBB
`define OPC_READ_QUAD 8'h6B
`define OPC_READ_QUAD_IO 8'hEB
`define OPC_CRM_RESET 8'hFF
`define OPC_ERASE_4K 8'h20
`define OPC_ERASE_32K 8'h52
`define OPC_ERASE_64K 8'hD8
`define OPC_CHIP_ERASE_A 8'h60
`define OPC_CHIP_ERASE_B 8'hC7
`define OPC_PROGRAM 8'h02
`define OPC_WRITE_ENABLE 8'h06
`define OPC_WRITE_DISABLE 8'h04
`define OPC_SEC_ERASE 8'h44
`define OPC_SEC_PROGRAM 8'h42
`define OPC_SEC_READ 8'h48
`define OPC_READ_SR1 8'h05
`define OPC_READ_SR2 8'h35
`define OPC_WRITE_SR 8'h01
`define OPC_VSR_ENABLE 8'h50
`define OPC_READ_JEDEC_ID 8'h9F
`define OPC_READ_ID_ADDR 8'h90

`define ADDR_BYTES 2'h3
`define BITS_PER_BYTE 4'h8
`define PROG_MAX_BYTES 9'h100
`define WRSR_MAX_BYTES 9'h002
`define IDLE_FILL_BYTE 8'hFF
`define RD_FIFO_DEPTH 8
`define RD_FIFO_WIDTH 8

`endif

// [flash_front_pkg.sv]
// types shared by the serial flash command front end
package flash_front_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_OPC    = 3'b001,
    ST_ADDR   = 3'b010,
    ST_DUMMY  = 3'b011,
    ST_DIN    = 3'b100,
    ST_DOUT   = 3'b101,
    ST_IGNORE = 3'b110,
    ST_DONE   = 3'b111
  } phase_t;

  typedef enum logic [1:0] {
    LANE_1 = 2'b00,
    LANE_2 = 2'b01,
    LANE_4 = 2'b10
  } lanes_t;

  typedef enum logic [1:0] {
    DIR_NONE = 2'b00,
    DIR_IN   = 2'b01,
    DIR_OUT  = 2'b10
  } dir_t;

  typedef struct packed {
    logic known;
    logic [1:0] addr_bytes;
    logic dummy;
    dir_t dir;
    lanes_t addr_lanes;
    lanes_t data_lanes;
  } cmd_info_t;

endpackage

// [spi_host.sv]
// spi master model that drives the link pins
`timescale 1ns/1ps
module spi_host (
  input wire logic clk_in, // system clock
  input wire logic [3:0] pin_in, // resolved io levels
  output logic cs_n_out, // chip select, active low
  output logic sck_out, // serial clock
  output logic [3:0] io_out // host io values
);
  logic cpol;

  initial begin
    cpol = 1'b0;
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    io_out = 4'hF;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic frame_on(input logic m);
    cpol = m;
    sck_out = m;
    tick(4);
    cs_n_out = 1'b0;
    tick(4);
  endtask

  // n clock cycles of ln lanes; send tx, collect the device's bits
  task automatic xfer(input logic [7:0] tx, input int ln, input int n,
    output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      sck_out = 1'b0;
      case (ln)
        1: io_out = {3'b110, tx[7]};
        2: io_out = {2'b11, tx[7:6]};
        default: io_out = tx[7:4];
      endcase
      tx = tx << ln;
      tick(4);
      sck_out = 1'b1;
      tick(4);
      case (ln)
        1: rx = {rx[6:0], pin_in[1]};
        2: rx = {rx[5:0], pin_in[1:0]};
        default: rx = {rx[3:0], pin_in};
      endcase
    end
  endtask

  task automatic frame_off();
    if (!cpol) sck_out = 1'b0;
    tick(4);
    cs_n_out = 1'b1;
    // released lines: io2/io3 pulled high, io0/io1 flip
    io_out = {2'b11, ~io_out[1:0]};
    tick(8);
  endtask
endmodule

// [front_end_checker_assertions.sv]
// concurrent checks on the command front end ports
`timescale 1ns/1ps
module front_end_checker (
  input wire logic clk_in, // clock
  input wire logic nrst_in, // reset
  input wire logic cs_n_in, // select
  input wire logic sck_in, // serial clock
  input wire logic [3:0] io_in, // pins
  input wire logic [3:0] io_out, // drive
  input wire logic [3:0] io_oe_n_out, // enables
  input wire logic cmd_valid_out, // header
  input wire logic [7:0] cmd_opcode_out, // opcode
  input wire logic [19:0] cmd_addr_out, // address
  input wire logic cmd_end_out, // end
  input wire logic crm_exit_out, // crm exit
  input wire logic wr_valid_out, // wr byte
  input wire logic [7:0] wr_byte_out, // wr data
  input wire logic rd_active_out, // reading
  input wire logic rd_underrun_out, // underrun
  input wire logic [7:0] rd_data_in, // rd data
  input wire logic rd_valid_in, // rd valid
  input wire logic rd_ready_out // rd ready
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  chk_oe_idle: assert property (cs_n_in [*6] |->
    io_oe_n_out == 4'hF)
    else $error("lines driven while deselected");
  chk_quad_oe: assert property (io_oe_n_out == 4'h0 |->
    cmd_opcode_out inside {8'h6B, 8'hEB})
    else $error("quad drive outside quad read");
  chk_dual_oe: assert property (io_oe_n_out == 4'hC |->
    cmd_opcode_out inside {8'h3B, 8'hBB})
    else $error("dual drive outside dual read");
  chk_crm_exit: assert property (crm_exit_out |->
    cmd_valid_out && cmd_opcode_out == 8'hFF)
    else $error("crm exit without FF");
  chk_wr_opcode: assert property (wr_valid_out |->
    cmd_opcode_out inside {8'h02, 8'h42, 8'h01})
    else $error("write byte for a non-write");
  chk_cmd_pulse: assert property (cmd_valid_out |=> !cmd_valid_out)
    else $error("header pulse too long");
  chk_end_cs: assert property (cmd_end_out |-> $past(cs_n_in, 2))
    else $error("end pulse while selected");
  chk_out_edge: assert property (rd_active_out && $changed(io_out) |->
    !$past(sck_in, 2))
    else $error("data changed after rising edge");
  chk_fifo_wakes: assert property ($rose(nrst_in) |=> rd_ready_out)
    else $error("fifo not ready after reset");
endmodule

bind serial_flash_command_front_end front_end_checker u_chk (.clk_in,
  .nrst_in, .cs_n_in, .sck_in, .io_in, .io_out, .io_oe_n_out,
  .cmd_valid_out, .cmd_opcode_out, .cmd_addr_out, .cmd_end_out,
  .crm_exit_out, .wr_valid_out, .wr_byte_out, .rd_active_out,
  .rd_underrun_out, .rd_data_in, .rd_valid_in, .rd_ready_out);

// [testbench.sv]
// self-checking bench for the serial flash command front end
`timescale 1ns/1ps
module testbench;
  logic clk_in, nrst_in, rd_valid_in, go, cs_n, sck;
  logic cv, ce, crm, wv, ra, und, rr;
  logic [7:0] rd_data_in, op, wb;
  logic [3:0] hio, dio, oe_n, pins;
  logic [19:0] ad;
  logic [7:0] feed[$];
  logic [7:0] wq[$];
  int failures = 0;
  int checks_done = 0;
  int nv = 0, ne = 0, nc = 0, nu = 0;

  assign pins = (~oe_n & dio) | (oe_n & hio);

  serial_flash_command_front_end u_dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .cs_n_in(cs_n), .sck_in(sck), .io_in(pins), .io_out(dio),
    .io_oe_n_out(oe_n), .cmd_valid_out(cv), .cmd_opcode_out(op),
    .cmd_addr_out(ad), .cmd_end_out(ce), .crm_exit_out(crm),
    .wr_valid_out(wv), .wr_byte_out(wb), .rd_active_out(ra),
    .rd_underrun_out(und), .rd_data_in(rd_data_in),
    .rd_valid_in(rd_valid_in), .rd_ready_out(rr));
  spi_host u_host (.clk_in(clk_in), .pin_in(pins), .cs_n_out(cs_n),
    .sck_out(sck), .io_out(hio));

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // feeds read bytes only after the header pulse has flushed the fifo;
  // disarms itself once chip select is released, so no task touches go
  always @(negedge clk_in) begin
    rd_valid_in <= go && rr === 1'b1 && feed.size() > 0;
    if (go && rr === 1'b1 && feed.size() > 0) rd_data_in <= feed.pop_front();
    go <= (go | (cv === 1'b1)) & (cs_n === 1'b0);
    if (cv === 1'b1) nv++;
    if (ce === 1'b1) ne++;
    if (crm === 1'b1) nc++;
    if (und === 1'b1) nu++;
    if (wv === 1'b1) wq.push_back(wb);
  end

  task automatic chk(input string nm, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic hdr(input logic [7:0] o, input int al, input logic m);
    logic [7:0] r;
    logic [23:0] a;
    a = 24'hF2C3A5;
    u_host.frame_on(m);
    u_host.xfer(o, 1, 8, r);
    if (al > 0)
      for (int k = 2; k >= 0; k--) u_host.xfer(a[k*8+:8], al, 8 / al, r);
  endtask

  task automatic tail(input logic [7:0] o, input int al, v0, e0);
    chk("cmd_count", v0 + 1, nv);
    chk("end_count", e0 + 1, ne);
    chk("opcode", o, op);
    chk("addr", al > 0 ? 20'h2C3A5 : 20'h0, ad);
    chk("oe_idle", 4'hF, oe_n);
  endtask

  task automatic rd_cmd(input logic [7:0] o, input int al, dl, nd, nb,
    input logic [3:0] xoe, input logic m);
    logic [7:0] r;
    int v0, e0, u0;
    v0 = nv;
    e0 = ne;
    u0 = nu;
    feed = {};
    for (int i = 0; i < nb && i < 8; i++) feed.push_back(o ^ 8'(i));
    hdr(o, al, m);
    if (nd > 0) u_host.xfer(8'hFF, nd, 8 / nd, r);
    if (nb > 8) chk("rd_ready_full", 0, rr);
    for (int i = 0; i < nb; i++) begin
      u_host.xfer(8'hFF, dl, 8 / dl, r);
      chk("rd_byte", i < 8 ? o ^ 8'(i) : 8'hFF, r);
      chk("io_oe", xoe, oe_n);
      chk("rd_active", 1, ra);
    end
    u_host.frame_off();
    tail(o, al, v0, e0);
    // mode 0 parks the clock low before release: one more slot, fifo empty
    chk("underrun", u0 + (nb > 8) + !m, nu);
  endtask

  task automatic wr_cmd(input logic [7:0] o, input int al, nb, xw);
    logic [7:0] r;
    int v0, e0;
    v0 = nv;
    e0 = ne;
    wq = {};
    hdr(o, al, o[0]);
    for (int i = 0; i < nb; i++) u_host.xfer(8'hA5 ^ 8'(i), 1, 8, r);
    chk("io_oe_in", 4'hF, oe_n);
    u_host.frame_off();
    tail(o, al, v0, e0);
    chk("wr_count", xw, wq.size());
    foreach (wq[i]) chk("wr_byte", 8'hA5 ^ 8'(i), wq[i]);
  endtask

  // unknown opcode, then a header cut short inside a byte
  task automatic bad_cmd();
    logic [7:0] r;
    int v0, e0;
    v0 = nv;
    e0 = ne;
    u_host.frame_on(1'b0);
    u_host.xfer(8'hA5, 1, 8, r);
    u_host.xfer(8'h03, 1, 8, r);
    u_host.frame_off();
    u_host.frame_on(1'b1);
    u_host.xfer(8'h0B, 1, 8, r);
    u_host.xfer(8'h12, 1, 8, r);
    u_host.xfer(8'h34, 1, 8, r);
    u_host.xfer(8'h56, 1, 3, r);
    u_host.frame_off();
    chk("no_cmd", v0, nv);
    chk("no_end", e0, ne);
    chk("oe_idle", 4'hF, oe_n);
  endtask

  initial begin
    logic [7:0] tab[9] = '{8'h20, 8'h52, 8'hD8, 8'h44, 8'h50, 8'h60,
      8'hC7, 8'h06, 8'h04};
    int c0;
    nrst_in = 1'b0;
    rd_valid_in = 1'b0;
    rd_data_in = 8'h00;
    go = 1'b0;
    repeat (8) @(negedge clk_in);
    nrst_in = 1'b1;
    repeat (4) @(negedge clk_in);
    chk("rd_ready", 1, rr);
    rd_cmd(8'h0B, 1, 1, 1, 9, 4'hD, 1'b0);
    rd_cmd(8'h03, 1, 1, 0, 2, 4'hD, 1'b1);
    rd_cmd(8'h3B, 1, 2, 1, 2, 4'hC, 1'b0);
    rd_cmd(8'h6B, 1, 4, 1, 2, 4'h0, 1'b1);
    rd_cmd(8'hEB, 4, 4, 4, 2, 4'h0, 1'b0);
    rd_cmd(8'hBB, 2, 2, 0, 2, 4'hC, 1'b1);
    rd_cmd(8'h48, 1, 1, 1, 2, 4'hD, 1'b0);
    rd_cmd(8'h05, 0, 1, 0, 1, 4'hD, 1'b1);
    rd_cmd(8'h35, 0, 1, 0, 1, 4'hD, 1'b0);
    bad_cmd();
    rd_cmd(8'h9F, 0, 1, 0, 3, 4'hD, 1'b1);
    rd_cmd(8'h90, 1, 1, 0, 2, 4'hD, 1'b0);
    wr_cmd(8'h02, 1, 257, 256);
    wr_cmd(8'h42, 1, 2, 2);
    wr_cmd(8'h01, 0, 3, 2);
    foreach (tab[i]) wr_cmd(tab[i], i < 4, 1, 0);
    c0 = nc;
    wr_cmd(8'hFF, 0, 1, 0);
    wr_cmd(8'hFF, 0, 0, 0);
    chk("crm_exit", c0 + 2, nc);
    finish_test();
  end

  initial begin
    repeat (100000) @(posedge clk_in);
    failures++;
    finish_test();
  end
endmodule
